// File: logic/sir_pkg.sv
// Shared constants for the sensor input register bank
package sir_pkg;

  // ----------------------------------------------------------------
  // Register addresses (Modbus input register numbers)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_TEMPERATURE_READING = 16'h0001;
  localparam logic [15:0] ADDR_HUMIDITY_READING = 16'h0002;
  localparam logic [15:0] ADDR_DEW_POINT_READING = 16'h0003;
  localparam logic [15:0] ADDR_RESERVED_A_FIRST = 16'h0004;
  localparam logic [15:0] ADDR_RESERVED_A_LAST = 16'h000a;
  localparam logic [15:0] ADDR_TEMPERATURE_OUTPUT_LEVEL = 16'h000b;
  localparam logic [15:0] ADDR_HUMIDITY_OUTPUT_LEVEL = 16'h000c;
  localparam logic [15:0] ADDR_TEMPERATURE_RELAY_STATE = 16'h000d;
  localparam logic [15:0] ADDR_HUMIDITY_RELAY_STATE = 16'h000e;
  localparam logic [15:0] ADDR_ACTIVE_TEMPERATURE_RANGE = 16'h000f;
  localparam logic [15:0] ADDR_ACTIVE_HUMIDITY_RANGE = 16'h0010;
  localparam logic [15:0] ADDR_ACTIVE_TEMPERATURE_SETPOINT = 16'h0011;
  localparam logic [15:0] ADDR_ACTIVE_HUMIDITY_SETPOINT = 16'h0012;
  localparam logic [15:0] ADDR_TEMPERATURE_HYSTERESIS = 16'h0013;
  localparam logic [15:0] ADDR_HUMIDITY_HYSTERESIS = 16'h0014;
  localparam logic [15:0] ADDR_TEMPERATURE_SETPOINT_OUT_OF_RANGE = 16'h0015;
  localparam logic [15:0] ADDR_HUMIDITY_SETPOINT_OUT_OF_RANGE = 16'h0016;
  localparam logic [15:0] ADDR_RESERVED_B_FIRST = 16'h0017;
  localparam logic [15:0] ADDR_RESERVED_B_LAST = 16'h001d;
  localparam logic [15:0] ADDR_SENSOR_LINK_LOST = 16'h001e;

  // ----------------------------------------------------------------
  // Range codes and modes
  // ----------------------------------------------------------------
  localparam logic [2:0] RANGE_CODE_1 = 3'h1;
  localparam logic [2:0] RANGE_CODE_2 = 3'h2;
  localparam logic [2:0] RANGE_CODE_3 = 3'h3;
  localparam logic [2:0] RANGE_CODE_4 = 3'h4;
  localparam logic [2:0] RANGE_CODE_CUSTOM = 3'h5;
  localparam logic MODE_STANDALONE = 1'b0;
  localparam logic MODE_BUS = 1'b1;

  // ----------------------------------------------------------------
  // Range bounds in tenths
  // ----------------------------------------------------------------
  localparam logic signed [15:0] TEMP_R1_LO = 16'sh0000;
  localparam logic signed [15:0] TEMP_R1_HI = 16'sh012c;
  localparam logic signed [15:0] TEMP_R2_LO = 16'sh0064;
  localparam logic signed [15:0] TEMP_R2_HI = 16'sh0190;
  localparam logic signed [15:0] TEMP_R3_LO = 16'sh00c8;
  localparam logic signed [15:0] TEMP_R3_HI = 16'sh01f4;
  localparam logic signed [15:0] TEMP_R4_LO = 16'sh0000;
  localparam logic signed [15:0] TEMP_R4_HI = 16'sh01f4;
  localparam logic [15:0] HUM_R1_LO = 16'h00c8;
  localparam logic [15:0] HUM_R1_HI = 16'h0384;
  localparam logic [15:0] HUM_R2_LO = 16'h0000;
  localparam logic [15:0] HUM_R2_HI = 16'h0258;
  localparam logic [15:0] HUM_R3_LO = 16'h0000;
  localparam logic [15:0] HUM_R3_HI = 16'h0320;
  localparam logic [15:0] HUM_R4_LO = 16'h0000;
  localparam logic [15:0] HUM_R4_HI = 16'h03e8;

  // ----------------------------------------------------------------
  // Setpoint limits, hysteresis defaults, reset values
  // ----------------------------------------------------------------
  localparam logic signed [15:0] TEMP_SETPOINT_MIN = 16'sh0000;
  localparam logic signed [15:0] TEMP_SETPOINT_MAX = 16'sh01f4;
  localparam logic [15:0] HUM_SETPOINT_MAX = 16'h03e8;
  localparam logic [15:0] TEMP_HYSTERESIS_DEFAULT = 16'h0014;
  localparam logic [15:0] HUM_HYSTERESIS_DEFAULT = 16'h0032;
  localparam logic [15:0] RESET_DATA = 16'h0000;
  localparam logic [2:0] RESET_RANGE = 3'h1;
  localparam logic [2:0] RESET_JUMPER = 3'h0;

endpackage

// File: logic/sir_register_bank.sv
// Read-only input register bank of the temperature and humidity sensor
`timescale 1ns/1ps

// What this block does
// R1 - Register 1 returns the measured temperature as a signed count of tenths of a degree.
// R2 - Register 2 returns the measured relative humidity as an unsigned count of tenths of a percent.
// R3 - Reserved addresses 4 to 10 and 23 to 29 read as zero and cannot be changed by any write.
// R4 - Registers 11 and 12 return each analogue output level as 0 to 1000 for 0 to 100 percent of scale.
// R5 - Registers 13 and 14 read 1 while the relay is energised and 0 while it is released.
// R6 - Register 15 holds temperature range code 1 to 5, from the jumper or from the configuration by mode.
// R7 - Register 16 holds humidity range code 1 to 5, from the jumper or from the configuration by mode.
// R8 - Register 17 holds the temperature setpoint in use, 0 to 500, from the trimmer or the configuration.
// R9 - Register 18 holds the humidity setpoint in use, 0 to 1000, from the trimmer or the configuration.
// R10 - Register 19 shows the temperature relay hysteresis in tenths of a degree.
// R11 - Register 20 shows the humidity relay hysteresis in tenths of a percent.
// R12 - Register 21 reads 1 while the temperature setpoint is outside the working range, else 0.
// R13 - Register 22 reads 1 while the humidity setpoint is outside the working range, else 0.
// R14 - Register 30 reads 1 while the link to the sensor module has failed, else 0.
// R15 - Mode 0 uses jumpers and trimmers, mode 1 lets the configuration override them.
module sir_register_bank #(
  parameter logic [15:0] TEMP_HYSTERESIS = sir_pkg::TEMP_HYSTERESIS_DEFAULT,
  parameter logic [15:0] HUM_HYSTERESIS = sir_pkg::HUM_HYSTERESIS_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register read port from the frame engine
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic addr_err_o,
  // Measurement path, same clock
  input wire logic signed [15:0] temperature_i,
  input wire logic [15:0] humidity_i,
  input wire logic signed [15:0] dew_point_i,
  input wire logic [15:0] temperature_analog_out_i,
  input wire logic [15:0] humidity_analog_out_i,
  input wire logic temperature_relay_on_i,
  input wire logic humidity_relay_on_i,
  input wire logic sensor_link_fail_i,
  // Trimmer readings, same clock
  input wire logic signed [15:0] temperature_trimmer_i,
  input wire logic [15:0] humidity_trimmer_i,
  // Range jumpers, from pins
  input wire logic [2:0] temperature_jumper_i,
  input wire logic [2:0] humidity_jumper_i,
  // Configuration, same clock
  input wire logic operating_mode_i,
  input wire logic [2:0] cfg_temperature_range_i,
  input wire logic [2:0] cfg_humidity_range_i,
  input wire logic signed [15:0] cfg_temperature_min_i,
  input wire logic signed [15:0] cfg_temperature_max_i,
  input wire logic [15:0] cfg_humidity_min_i,
  input wire logic [15:0] cfg_humidity_max_i,
  input wire logic signed [15:0] cfg_temperature_setpoint_i,
  input wire logic [15:0] cfg_humidity_setpoint_i
);

  // ----------------------------------------------------------------
  // Jumper synchronisers
  // ----------------------------------------------------------------
  logic [2:0] tj_meta_q, tj_meta_d, tj_sync_q, tj_sync_d;
  logic [2:0] hj_meta_q, hj_meta_d, hj_sync_q, hj_sync_d;

  always_comb begin
    tj_meta_d = temperature_jumper_i;
    tj_sync_d = tj_meta_q;
    hj_meta_d = humidity_jumper_i;
    hj_sync_d = hj_meta_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tj_meta_q <= sir_pkg::RESET_JUMPER;
      tj_sync_q <= sir_pkg::RESET_JUMPER;
      hj_meta_q <= sir_pkg::RESET_JUMPER;
      hj_sync_q <= sir_pkg::RESET_JUMPER;
    end else if (ce_i) begin
      tj_meta_q <= tj_meta_d;
      tj_sync_q <= tj_sync_d;
      hj_meta_q <= hj_meta_d;
      hj_sync_q <= hj_sync_d;
    end
  end

  // ----------------------------------------------------------------
  // Active range, setpoint and out-of-range status
  // ----------------------------------------------------------------
  logic [2:0] trange_q, trange_d, hrange_q, hrange_d;
  logic signed [15:0] tsp_q, tsp_d;
  logic [15:0] hsp_q, hsp_d;
  logic tflag_q, tflag_d, hflag_q, hflag_d;
  logic [2:0] tcode, hcode;
  logic signed [15:0] tsel, tlo, thi;
  logic [15:0] hsel, hlo, hhi;

  always_comb begin
    // Configuration overrides jumpers and trimmers only in bus mode
    if (operating_mode_i == sir_pkg::MODE_BUS) begin // R15
      tcode = cfg_temperature_range_i;
      hcode = cfg_humidity_range_i;
      tsel = cfg_temperature_setpoint_i;
      hsel = cfg_humidity_setpoint_i;
    end else begin
      tcode = tj_sync_q;
      hcode = hj_sync_q;
      tsel = temperature_trimmer_i;
      hsel = humidity_trimmer_i;
    end
    // Unknown codes fall back to the first range
    if (tcode >= sir_pkg::RANGE_CODE_1 && tcode <= sir_pkg::RANGE_CODE_CUSTOM) begin // R6
      trange_d = tcode;
    end else begin
      trange_d = sir_pkg::RANGE_CODE_1;
    end
    if (hcode >= sir_pkg::RANGE_CODE_1 && hcode <= sir_pkg::RANGE_CODE_CUSTOM) begin // R7
      hrange_d = hcode;
    end else begin
      hrange_d = sir_pkg::RANGE_CODE_1;
    end
    // Setpoints saturate to their legal span
    if (tsel < sir_pkg::TEMP_SETPOINT_MIN) begin // R8
      tsp_d = sir_pkg::TEMP_SETPOINT_MIN;
    end else if (tsel > sir_pkg::TEMP_SETPOINT_MAX) begin
      tsp_d = sir_pkg::TEMP_SETPOINT_MAX;
    end else begin
      tsp_d = tsel;
    end
    if (hsel > sir_pkg::HUM_SETPOINT_MAX) begin // R9
      hsp_d = sir_pkg::HUM_SETPOINT_MAX;
    end else begin
      hsp_d = hsel;
    end
    unique case (trange_q)
      sir_pkg::RANGE_CODE_2: begin
        tlo = sir_pkg::TEMP_R2_LO;
        thi = sir_pkg::TEMP_R2_HI;
      end
      sir_pkg::RANGE_CODE_3: begin
        tlo = sir_pkg::TEMP_R3_LO;
        thi = sir_pkg::TEMP_R3_HI;
      end
      sir_pkg::RANGE_CODE_4: begin
        tlo = sir_pkg::TEMP_R4_LO;
        thi = sir_pkg::TEMP_R4_HI;
      end
      sir_pkg::RANGE_CODE_CUSTOM: begin
        tlo = cfg_temperature_min_i;
        thi = cfg_temperature_max_i;
      end
      default: begin
        tlo = sir_pkg::TEMP_R1_LO;
        thi = sir_pkg::TEMP_R1_HI;
      end
    endcase
    unique case (hrange_q)
      sir_pkg::RANGE_CODE_2: begin
        hlo = sir_pkg::HUM_R2_LO;
        hhi = sir_pkg::HUM_R2_HI;
      end
      sir_pkg::RANGE_CODE_3: begin
        hlo = sir_pkg::HUM_R3_LO;
        hhi = sir_pkg::HUM_R3_HI;
      end
      sir_pkg::RANGE_CODE_4: begin
        hlo = sir_pkg::HUM_R4_LO;
        hhi = sir_pkg::HUM_R4_HI;
      end
      sir_pkg::RANGE_CODE_CUSTOM: begin
        hlo = cfg_humidity_min_i;
        hhi = cfg_humidity_max_i;
      end
      default: begin
        hlo = sir_pkg::HUM_R1_LO;
        hhi = sir_pkg::HUM_R1_HI;
      end
    endcase
    tflag_d = (tsp_q < tlo) || (tsp_q > thi); // R12
    hflag_d = (hsp_q < hlo) || (hsp_q > hhi); // R13
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trange_q <= sir_pkg::RESET_RANGE;
      hrange_q <= sir_pkg::RESET_RANGE;
      tsp_q <= sir_pkg::RESET_DATA;
      hsp_q <= sir_pkg::RESET_DATA;
      tflag_q <= 1'b0;
      hflag_q <= 1'b0;
    end else if (ce_i) begin
      trange_q <= trange_d;
      hrange_q <= hrange_d;
      tsp_q <= tsp_d;
      hsp_q <= hsp_d;
      tflag_q <= tflag_d;
      hflag_q <= hflag_d;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d, err_q, err_d;
  logic [15:0] word;
  logic hit;

  always_comb begin
    word = sir_pkg::RESET_DATA;
    hit = 1'b1;
    unique case (addr_i)
      sir_pkg::ADDR_TEMPERATURE_READING: word = temperature_i; // R1
      sir_pkg::ADDR_HUMIDITY_READING: word = humidity_i; // R2
      sir_pkg::ADDR_DEW_POINT_READING: word = dew_point_i;
      sir_pkg::ADDR_TEMPERATURE_OUTPUT_LEVEL: word = temperature_analog_out_i; // R4
      sir_pkg::ADDR_HUMIDITY_OUTPUT_LEVEL: word = humidity_analog_out_i; // R4
      sir_pkg::ADDR_TEMPERATURE_RELAY_STATE: word = {15'h0000, temperature_relay_on_i}; // R5
      sir_pkg::ADDR_HUMIDITY_RELAY_STATE: word = {15'h0000, humidity_relay_on_i}; // R5
      sir_pkg::ADDR_ACTIVE_TEMPERATURE_RANGE: word = {13'h0000, trange_q}; // R6
      sir_pkg::ADDR_ACTIVE_HUMIDITY_RANGE: word = {13'h0000, hrange_q}; // R7
      sir_pkg::ADDR_ACTIVE_TEMPERATURE_SETPOINT: word = tsp_q; // R8
      sir_pkg::ADDR_ACTIVE_HUMIDITY_SETPOINT: word = hsp_q; // R9
      sir_pkg::ADDR_TEMPERATURE_HYSTERESIS: word = TEMP_HYSTERESIS; // R10
      sir_pkg::ADDR_HUMIDITY_HYSTERESIS: word = HUM_HYSTERESIS; // R11
      sir_pkg::ADDR_TEMPERATURE_SETPOINT_OUT_OF_RANGE: word = {15'h0000, tflag_q}; // R12
      sir_pkg::ADDR_HUMIDITY_SETPOINT_OUT_OF_RANGE: word = {15'h0000, hflag_q}; // R13
      sir_pkg::ADDR_SENSOR_LINK_LOST: word = {15'h0000, sensor_link_fail_i}; // R14
      default: begin
        // Reserved words read zero; anything outside the map is flagged
        word = sir_pkg::RESET_DATA; // R3
        hit = ((addr_i >= sir_pkg::ADDR_RESERVED_A_FIRST) && (addr_i <= sir_pkg::ADDR_RESERVED_A_LAST)) ||
              ((addr_i >= sir_pkg::ADDR_RESERVED_B_FIRST) && (addr_i <= sir_pkg::ADDR_RESERVED_B_LAST));
      end
    endcase
    rvalid_d = rd_i;
    err_d = rd_i && !hit;
    rdata_d = rd_i ? word : rdata_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= sir_pkg::RESET_DATA;
      rvalid_q <= 1'b0;
      err_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      err_q <= err_d;
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign addr_err_o = err_q;

endmodule

// File: test/sir_modbus_master.sv
// Behavioural bus master issuing single-word input register reads
`timescale 1ns/1ps
module sir_modbus_master (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic addr_err_i,
  input wire logic [15:0] rdata_i,
  output logic rd_o,
  output logic [15:0] addr_o
);
  initial begin
    rd_o = 1'b0;
    addr_o = 16'h0000;
  end
  // Address is scrambled once released so a stale value never reads as held
  task automatic read(input logic [15:0] a, input int unsigned gap, output logic [16:0] ans);
    int n;
    ans = 'x;
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    for (n = 0; n < 4; n++) begin
      #1;
      if (rvalid_i === 1'b1) begin
        ans = {addr_err_i, rdata_i};
        break;
      end
      @(posedge clk_i);
    end
  endtask
endmodule

// File: test/sir_register_bank_asserts.sv
// Port-level checks on the sensor input register bank
`timescale 1ns/1ps
module sir_register_bank_asserts #(
  parameter logic [15:0] TEMP_HYSTERESIS = 16'h0014
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic addr_err_o,
  input wire logic signed [15:0] temperature_i,
  input wire logic [15:0] humidity_i,
  input wire logic [15:0] temperature_analog_out_i,
  input wire logic temperature_relay_on_i,
  input wire logic sensor_link_fail_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rq;
  assign rq = rd_i && ce_i;
  a_temp_live: assert property (rq && addr_i == 16'h0001 |=> rvalid_o && rdata_o == $past(temperature_i))
    else $error("temperature word wrong");
  a_hum_live: assert property (rq && addr_i == 16'h0002 |=> rdata_o == $past(humidity_i))
    else $error("humidity word wrong");
  a_reserved_zero: assert property (rq && addr_i inside {[4:10], [23:29]} |=> !addr_err_o && rdata_o == 16'h0)
    else $error("reserved word not zero");
  a_output_level: assert property (rq && addr_i == 16'h000b |=> rdata_o == $past(temperature_analog_out_i))
    else $error("output level word wrong");
  a_relay_state: assert property (rq && addr_i == 16'h000d |=> rdata_o == {15'h0, $past(temperature_relay_on_i)})
    else $error("relay word wrong");
  a_range_code: assert property (rq && addr_i inside {15, 16} |=> rdata_o inside {[1:5]})
    else $error("range code outside 1 to 5");
  a_temp_setpoint: assert property (rq && addr_i == 16'h0011 |=> rdata_o <= 16'h01f4)
    else $error("setpoint outside 0 to 500");
  a_temp_hyst: assert property (rq && addr_i == 16'h0013 |=> rdata_o == TEMP_HYSTERESIS)
    else $error("hysteresis word wrong");
  a_flag_bit: assert property (rq && addr_i inside {21, 22} |=> rdata_o[15:1] == 15'h0)
    else $error("flag word wider than one bit");
  a_link_lost: assert property (rq && addr_i == 16'h001e |=> rdata_o == {15'h0, $past(sensor_link_fail_i)})
    else $error("link lost word wrong");
endmodule
bind sir_register_bank sir_register_bank_asserts #(.TEMP_HYSTERESIS(TEMP_HYSTERESIS)) chk_inst (.clk_i, .rst_n_i,
  .ce_i, .rd_i, .addr_i, .rdata_o, .rvalid_o, .addr_err_o, .temperature_i, .humidity_i, .temperature_analog_out_i,
  .temperature_relay_on_i, .sensor_link_fail_i);

// File: test/sir_register_bank_tb.sv
// Self-checking bench for the sensor input register bank
`timescale 1ns/1ps
module sir_register_bank_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic rd, rvalid, aerr, t_on, h_on, fail, mode;
  logic [15:0] addr, rdata, hum, dew, t_ao, h_ao, h_trim, c_hmin, c_hmax, c_hsp;
  logic signed [15:0] temp, t_trim, c_tmin, c_tmax, c_tsp;
  logic [2:0] t_jmp, h_jmp, c_tr, c_hr;
  logic [16:0] got;
  int fails = 0;
  int cmp_count = 0;
  int it, a;
  always #2 clk = ~clk;
  sir_register_bank sir_register_bank_inst (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .rd_i(rd), .addr_i(addr), .rdata_o(rdata), .rvalid_o(rvalid),
    .addr_err_o(aerr), .temperature_i(temp), .humidity_i(hum), .dew_point_i(dew),
    .temperature_analog_out_i(t_ao), .humidity_analog_out_i(h_ao), .temperature_relay_on_i(t_on),
    .humidity_relay_on_i(h_on), .sensor_link_fail_i(fail), .temperature_trimmer_i(t_trim),
    .humidity_trimmer_i(h_trim), .temperature_jumper_i(t_jmp), .humidity_jumper_i(h_jmp),
    .operating_mode_i(mode), .cfg_temperature_range_i(c_tr), .cfg_humidity_range_i(c_hr),
    .cfg_temperature_min_i(c_tmin), .cfg_temperature_max_i(c_tmax), .cfg_humidity_min_i(c_hmin),
    .cfg_humidity_max_i(c_hmax), .cfg_temperature_setpoint_i(c_tsp), .cfg_humidity_setpoint_i(c_hsp)
  );
  sir_modbus_master sir_modbus_master_inst (
    .clk_i(clk), .rvalid_i(rvalid), .addr_err_i(aerr), .rdata_i(rdata), .rd_o(rd), .addr_o(addr)
  );
  task automatic scramble();
    temp <= 16'($urandom);
    dew <= 16'($urandom);
    hum <= 16'($urandom_range(0, 1000));
    t_ao <= 16'($urandom_range(0, 1000));
    h_ao <= 16'($urandom_range(0, 1000));
    {t_on, h_on, fail, mode, t_jmp, h_jmp, c_tr, c_hr} <= 16'($urandom);
    // Setpoints stray past their span so saturation is exercised
    t_trim <= 16'($urandom_range(0, 700) - 100);
    c_tsp <= 16'($urandom_range(0, 700) - 100);
    h_trim <= 16'($urandom_range(0, 1100));
    c_hsp <= 16'($urandom_range(0, 1100));
    c_tmin <= 16'($urandom_range(0, 250));
    c_tmax <= 16'($urandom_range(250, 500));
    c_hmin <= 16'($urandom_range(0, 500));
    c_hmax <= 16'($urandom_range(500, 1000));
  endtask
  function automatic logic [16:0] expect_word(int a);
    int tl[5] = '{0, 0, 100, 200, 0};
    int th[5] = '{0, 300, 400, 500, 500};
    int hl[5] = '{0, 200, 0, 0, 0};
    int hh[5] = '{0, 900, 600, 800, 1000};
    int tc, hc, ts, hs;
    tc = mode ? c_tr : t_jmp;
    hc = mode ? c_hr : h_jmp;
    if (tc < 1 || tc > 5) tc = 1;
    if (hc < 1 || hc > 5) hc = 1;
    ts = mode ? c_tsp : t_trim;
    ts = ts < 0 ? 0 : (ts > 500 ? 500 : ts);
    hs = mode ? c_hsp : h_trim;
    hs = hs > 1000 ? 1000 : hs;
    case (a)
      1: return {1'b0, temp};
      2: return {1'b0, hum};
      3: return {1'b0, dew};
      11: return {1'b0, t_ao};
      12: return {1'b0, h_ao};
      13: return 17'(t_on);
      14: return 17'(h_on);
      15: return 17'(tc);
      16: return 17'(hc);
      17: return 17'(ts);
      18: return 17'(hs);
      19: return 17'd20;
      20: return 17'd50;
      21: return 17'(ts < (tc == 5 ? c_tmin : tl[tc]) || ts > (tc == 5 ? c_tmax : th[tc]));
      22: return 17'(hs < (hc == 5 ? c_hmin : hl[hc]) || hs > (hc == 5 ? c_hmax : hh[hc]));
      30: return 17'(fail);
      default: return (a == 0 || a > 30) ? 17'h10000 : 17'h00000;
    endcase
  endfunction
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hc46f));
    scramble();
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (it = 0; it < 60; it++) begin
      @(posedge clk);
      scramble();
      if (it == 30) begin
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
      end
      // Jumper synchronisers and status registers settle first
      repeat (6) @(posedge clk);
      for (a = 0; a < 33; a++) begin
        sir_modbus_master_inst.read(16'(a), it % 3, got);
        chk(got, expect_word(a));
      end
      // Frozen clock enable: a read is ignored and the last answer, a zero word, holds
      if (it % 20 == 10) begin
        @(posedge clk);
        ce <= 1'b0;
        sir_modbus_master_inst.read(16'h0001, 0, got);
        #1;
        chk({rvalid, rdata}, 17'h00000);
        @(posedge clk);
        ce <= 1'b1;
      end
    end
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
